/* File: design/dcf_pkg.sv */
// Purpose: shared constants for the single clock flagged fifo and its controller
// Assumes: both fifo ports and the controller share one clock
// Notes: pin-level flags and strobes are active low
package dcf_pkg;
	// ****************************************************
	// data path and depth
	// ****************************************************
	localparam int DCF_DATA_W = 18;
	localparam int DCF_DEPTH_DEF = 65536;
	localparam int DCF_SYNC_STAGES = 2;
	localparam int DCF_OFS_SMALL = 127;
	localparam int DCF_OFS_LARGE = 1023;

	// ****************************************************
	// controller register map (byte addresses)
	// ****************************************************
	localparam logic [7:0] DCF_REG_CTRL = 8'h00;
	localparam logic [7:0] DCF_REG_WDATA = 8'h04;
	localparam logic [7:0] DCF_REG_CMD = 8'h08;
	localparam logic [7:0] DCF_REG_RDATA = 8'h0C;
	localparam logic [7:0] DCF_REG_STATUS = 8'h10;
	localparam logic [31:0] DCF_CTRL_RESET = 32'h0000_0000;

	// ctrl fields
	localparam int DCF_CTRL_FULL_RST = 0;
	localparam int DCF_CTRL_DATA_RST = 1;
	localparam int DCF_CTRL_FWFT = 2;
	localparam int DCF_CTRL_OFS_SEL = 3;
	localparam int DCF_CTRL_OUT_EN = 4;
	localparam int DCF_CTRL_W = 5;

	// cmd fields; read, shift and replay are one-cycle strobes, sbit is the bit shifted in
	localparam int DCF_CMD_READ = 0;
	localparam int DCF_CMD_SHIFT = 1;
	localparam int DCF_CMD_SBIT = 2;
	localparam int DCF_CMD_REPLAY = 3;

	// status fields, raw pin levels
	localparam int DCF_ST_FULL = 0;
	localparam int DCF_ST_EMPTY = 1;
	localparam int DCF_ST_AFULL = 2;
	localparam int DCF_ST_AEMPTY = 3;
	localparam int DCF_ST_HALF = 4;
	localparam int DCF_ST_W = 5;
endpackage

/* File: design/dcf_link_if.sv */
// Purpose: pin bundle between the fifo and its producer/consumer controller
// Assumes: all pins are synchronous to the shared clock
// Notes: read data is two signals worth: value plus drive enable
`timescale 1ns/10ps
interface dcf_link_if;
	import dcf_pkg::*;
	logic full_reset_n;
	logic data_only_reset_n;
	logic replay_request_n;
	logic write_en_n;
	logic read_en_n;
	logic serial_load_enable_n;
	logic offset_access_select_n;
	logic mode_serial_in;
	logic tie_off_pin;
	logic output_drive_en_n;
	logic [DCF_DATA_W-1:0] write_data_in;
	logic [DCF_DATA_W-1:0] read_data_out;
	logic read_data_oe;
	logic full_flag_n;
	logic empty_flag_n;
	logic almost_full_flag_n;
	logic almost_empty_flag_n;
	logic half_full_flag_n;

	// fifo end
	modport dev (
		input full_reset_n, data_only_reset_n, replay_request_n, write_en_n, read_en_n,
		input serial_load_enable_n, offset_access_select_n, mode_serial_in, tie_off_pin,
		input output_drive_en_n, write_data_in,
		output read_data_out, read_data_oe, full_flag_n, empty_flag_n,
		output almost_full_flag_n, almost_empty_flag_n, half_full_flag_n
	);

	// controller end
	modport host (
		output full_reset_n, data_only_reset_n, replay_request_n, write_en_n, read_en_n,
		output serial_load_enable_n, offset_access_select_n, mode_serial_in, tie_off_pin,
		output output_drive_en_n, write_data_in,
		input read_data_out, read_data_oe, full_flag_n, empty_flag_n,
		input almost_full_flag_n, almost_empty_flag_n, half_full_flag_n
	);
endinterface // dcf_link_if

/* File: design/dcf_device.sv */
// Purpose: flagged fifo with standard or fall-through timing and offset flags
// Assumes: both ports on pclk; pointer views pass through two-stage synchronisers
// Notes:
// Functional notes
// - both resets zero pointers and output register
// - full reset latches mode, default, method
// - data reset keeps mode, method, offsets
// - replay rewinds read pointer, shows empty briefly
// - mode pin is serial input after reset
// - enabled write stores word or offset
// - serial enable shifts one offset bit
// - enabled read outputs word or offset
// - access pin picks default and method
// - access pin redirects cycles to offsets
// - drive enable controls output drive
// - tie-off pin held constant after reset
// - standard mode: full flag on full
// - fall-through mode: input ready flag
// - standard mode: empty flag on empty
// - fall-through mode: output ready flag
// - almost full above capacity minus offset
// - almost empty below empty offset
// - half full above half capacity
// - data buses are eighteen bits
// - fall-through first word after three edges
// - standard first word needs read cycle
`timescale 1ns/10ps
module dcf_device import dcf_pkg::*; #(
	parameter int DEPTH = DCF_DEPTH_DEF
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// fifo pins
	dcf_link_if.dev link
);
	localparam int AW = $clog2(DEPTH);
	localparam logic [AW:0] CAP = (AW+1)'(DEPTH);
	localparam logic [AW:0] HALF = (AW+1)'(DEPTH / 2);

	// ****************************************************
	// elaboration checks
	// ****************************************************
	if (DEPTH < 2 * (DCF_OFS_LARGE + 1) || (1 << AW) != DEPTH || AW > DCF_DATA_W) begin : g_bad
		$error("DEPTH must be a power of two from 2048 to 2**18");
	end

	// ****************************************************
	// state
	// ****************************************************
	logic [DCF_DATA_W-1:0] mem_ff [DEPTH];
	logic [AW:0] wptr_ff, rptr_ff;
	logic [AW:0] wgray_ff, rgray_ff; // gray copies, the only pointer words that cross
	logic [AW:0] wptr_s1_ff, wptr_s2_ff, rptr_s1_ff, rptr_s2_ff;
	wire [AW:0] wptr_view, rptr_view; // synced gray turned back into binary
	logic [AW-1:0] empty_ofs_ff, full_ofs_ff;
	logic fwft_ff, serial_ff, ofs_wsel_ff, ofs_rsel_ff;
	logic [DCF_DATA_W-1:0] q_ff;
	logic valid_ff, replay_ff;

	// ****************************************************
	// pin decode
	// ****************************************************
	wire full_rst = ~link.full_reset_n;
	wire data_rst = ~link.data_only_reset_n;
	wire any_rst = full_rst | data_rst;
	wire wen = ~link.write_en_n;
	wire ren = ~link.read_en_n;
	wire ld = ~link.offset_access_select_n;
	wire serial_load_enable = ~link.serial_load_enable_n;
	wire replay = ~link.replay_request_n & ~any_rst;
	wire [AW-1:0] dflt_ofs = link.offset_access_select_n ? AW'(DCF_OFS_LARGE) : AW'(DCF_OFS_SMALL);

	// occupancy as seen by each side; each compares its own pointer with a synced one
	wire [AW:0] wr_count = wptr_ff - rptr_view;
	wire [AW:0] rd_count = wptr_view - rptr_ff;
	wire is_full = (wr_count == CAP);
	wire mem_has = (rd_count != '0);

	// operation strobes
	wire mem_we = wen & ~ld & ~is_full & ~any_rst;
	wire ofs_we = wen & ld & ~serial_ff & ~any_rst;
	wire ofs_sh = serial_load_enable & ld & serial_ff & ~any_rst;
	wire ofs_rd = ren & ld & ~replay & ~any_rst;
	wire fetch_ok = ~ld & ~replay & ~any_rst & mem_has;
	wire fetch = fetch_ok & (fwft_ff ? (~valid_ff | ren) : ren);
	wire drain = fwft_ff & ren & ~ld & ~fetch; // fall-through word consumed, none behind it
	// next pointers; resets return both to zero, replay only the read pointer
	wire [AW:0] nxt_wptr = any_rst ? '0 : (mem_we ? wptr_ff + 1'b1 : wptr_ff);
	wire [AW:0] nxt_rptr = (any_rst | replay) ? '0 : (fetch ? rptr_ff + 1'b1 : rptr_ff);
	wire [DCF_DATA_W-1:0] ofs_view = ofs_rsel_ff ? DCF_DATA_W'(full_ofs_ff) :
		DCF_DATA_W'(empty_ofs_ff);

	// ****************************************************
	// storage array, no reset needed
	// ****************************************************
	always_ff @(posedge pclk) begin
		if (mem_we) begin
			mem_ff[wptr_ff[AW-1:0]] <= link.write_data_in;
		end
	end

	// ****************************************************
	// write pointer and its gray copy
	// ****************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wptr_ff <= '0;
			wgray_ff <= '0;
		end else begin
			wptr_ff <= nxt_wptr; // wraps modulo twice the depth
			wgray_ff <= nxt_wptr ^ (nxt_wptr >> 1); // one bit moves per step
		end
	end

	// ****************************************************
	// read pointer and its gray copy
	// ****************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rptr_ff <= '0;
			rgray_ff <= '0;
		end else begin
			rptr_ff <= nxt_rptr;
			rgray_ff <= nxt_rptr ^ (nxt_rptr >> 1);
		end
	end

	// ****************************************************
	// pointer synchronisers, first stage feeds only the second
	// ****************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wptr_s1_ff <= '0;
			wptr_s2_ff <= '0;
			rptr_s1_ff <= '0;
			rptr_s2_ff <= '0;
		end else begin
			wptr_s1_ff <= wgray_ff;
			wptr_s2_ff <= wptr_s1_ff;
			rptr_s1_ff <= rgray_ff;
			rptr_s2_ff <= rptr_s1_ff;
		end
	end

	// gray to binary, each bit the parity of itself and the bits above it
	for (genvar gi = 0; gi <= AW; gi++) begin : g_ungray
		assign wptr_view[gi] = ^wptr_s2_ff[AW:gi];
		assign rptr_view[gi] = ^rptr_s2_ff[AW:gi];
	end

	// ****************************************************
	// configuration caught only under full reset
	// ****************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fwft_ff <= 1'b0;
			serial_ff <= 1'b0;
		end else if (full_rst) begin
			fwft_ff <= link.mode_serial_in;
			serial_ff <= link.offset_access_select_n; // high: serial, low: parallel
		end
	end

	// ****************************************************
	// offset registers: default, parallel load, serial shift
	// ****************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			empty_ofs_ff <= AW'(DCF_OFS_SMALL);
			full_ofs_ff <= AW'(DCF_OFS_SMALL);
		end else if (full_rst) begin
			empty_ofs_ff <= dflt_ofs;
			full_ofs_ff <= dflt_ofs;
		end else if (ofs_we) begin
			// empty offset first, then full offset
			if (ofs_wsel_ff) begin
				full_ofs_ff <= link.write_data_in[AW-1:0];
			end else begin
				empty_ofs_ff <= link.write_data_in[AW-1:0];
			end
		end else if (ofs_sh) begin
			// bit enters the top, so the first bit lands in empty bit 0
			{full_ofs_ff, empty_ofs_ff} <= {link.mode_serial_in, full_ofs_ff, empty_ofs_ff[AW-1:1]};
		end
	end

	// ****************************************************
	// offset access selectors, restart on any reset
	// ****************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ofs_wsel_ff <= 1'b0;
			ofs_rsel_ff <= 1'b0;
		end else if (any_rst) begin
			ofs_wsel_ff <= 1'b0; // data reset keeps values, only the selector restarts
			ofs_rsel_ff <= 1'b0;
		end else begin
			ofs_wsel_ff <= ofs_we ? ~ofs_wsel_ff : ofs_wsel_ff;
			ofs_rsel_ff <= ofs_rd ? ~ofs_rsel_ff : ofs_rsel_ff;
		end
	end

	// ****************************************************
	// output register and fall-through valid
	// ****************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q_ff <= '0;
			valid_ff <= 1'b0;
			replay_ff <= 1'b0;
		end else if (any_rst) begin
			q_ff <= '0;
			valid_ff <= 1'b0;
			replay_ff <= 1'b0;
		end else begin
			replay_ff <= replay; // one cycle of forced empty
			if (replay) begin
				valid_ff <= 1'b0;
			end else if (ofs_rd) begin
				q_ff <= ofs_view;
			end else if (fetch) begin
				q_ff <= mem_ff[rptr_ff[AW-1:0]];
				valid_ff <= 1'b1;
			end else if (drain) begin
				valid_ff <= 1'b0;
			end
		end
	end

	// ****************************************************
	// flags, all active low
	// ****************************************************
	assign link.full_flag_n = fwft_ff ? is_full : ~is_full;
	assign link.empty_flag_n = fwft_ff ? ~valid_ff : (mem_has & ~replay_ff);
	assign link.almost_full_flag_n = ~(wr_count > (CAP - {1'b0, full_ofs_ff}));
	assign link.almost_empty_flag_n = ~(rd_count < {1'b0, empty_ofs_ff});
	assign link.half_full_flag_n = ~(wr_count > HALF);

	// read data and its drive enable
	assign link.read_data_out = q_ff;
	assign link.read_data_oe = ~link.output_drive_en_n;
endmodule // dcf_device

/* File: design/dcf_host.sv */
// Purpose: producer/consumer controller driving the fifo pins from apb registers
// Assumes: zero-wait apb slave on pclk
// Notes: write, read, shift and replay are one-cycle pin strobes
`timescale 1ns/10ps
module dcf_host import dcf_pkg::*; #(
	parameter logic TIE_LEVEL = 1'b0
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// fifo pins
	dcf_link_if.host link
);
	// ****************************************************
	// state
	// ****************************************************
	logic [DCF_CTRL_W-1:0] ctrl_ff;
	logic [DCF_DATA_W-1:0] wdata_ff;
	logic wen_ff, ren_ff, shift_ff, sbit_ff, replay_ff;

	// ****************************************************
	// apb decode
	// ****************************************************
	wire access = psel & penable;
	wire wr_go = access & pwrite;
	wire hit_ctrl = (paddr == DCF_REG_CTRL);
	wire hit_wdata = (paddr == DCF_REG_WDATA);
	wire hit_cmd = (paddr == DCF_REG_CMD);
	wire hit_rdata = (paddr == DCF_REG_RDATA);
	wire hit_status = (paddr == DCF_REG_STATUS);
	wire mapped = hit_ctrl | hit_wdata | hit_cmd | hit_rdata | hit_status;
	wire [DCF_ST_W-1:0] status = {link.half_full_flag_n, link.almost_empty_flag_n,
		link.almost_full_flag_n, link.empty_flag_n, link.full_flag_n};

	// read mux and answer
	assign pready = 1'b1;
	assign pslverr = access & ~mapped;
	assign prdata = hit_ctrl ? 32'(ctrl_ff) :
		hit_wdata ? 32'(wdata_ff) :
		hit_rdata ? 32'(link.read_data_out) :
		hit_status ? 32'(status) : 32'h0000_0000;

	// ****************************************************
	// control register
	// ****************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_ff <= DCF_CTRL_RESET[DCF_CTRL_W-1:0];
		end else if (wr_go && hit_ctrl) begin
			ctrl_ff <= pwdata[DCF_CTRL_W-1:0];
		end
	end

	// ****************************************************
	// write data and pin strobes
	// ****************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wdata_ff <= '0;
			wen_ff <= 1'b0;
			ren_ff <= 1'b0;
			shift_ff <= 1'b0;
			sbit_ff <= 1'b0;
			replay_ff <= 1'b0;
		end else begin
			wen_ff <= wr_go & hit_wdata;
			ren_ff <= wr_go & hit_cmd & pwdata[DCF_CMD_READ];
			shift_ff <= wr_go & hit_cmd & pwdata[DCF_CMD_SHIFT];
			replay_ff <= wr_go & hit_cmd & pwdata[DCF_CMD_REPLAY];
			if (wr_go && hit_wdata) begin
				wdata_ff <= pwdata[DCF_DATA_W-1:0];
			end
			if (wr_go && hit_cmd && pwdata[DCF_CMD_SHIFT]) begin
				sbit_ff <= pwdata[DCF_CMD_SBIT];
			end
		end
	end

	// ****************************************************
	// pin drive
	// ****************************************************
	assign link.full_reset_n = ~ctrl_ff[DCF_CTRL_FULL_RST];
	assign link.data_only_reset_n = ~ctrl_ff[DCF_CTRL_DATA_RST];
	assign link.offset_access_select_n = ~ctrl_ff[DCF_CTRL_OFS_SEL];
	assign link.output_drive_en_n = ~ctrl_ff[DCF_CTRL_OUT_EN];
	assign link.mode_serial_in = ctrl_ff[DCF_CTRL_FULL_RST] ? ctrl_ff[DCF_CTRL_FWFT] : sbit_ff;
	assign link.write_en_n = ~wen_ff;
	assign link.read_en_n = ~ren_ff;
	assign link.serial_load_enable_n = ~shift_ff;
	assign link.replay_request_n = ~replay_ff;
	assign link.write_data_in = wdata_ff;
	assign link.tie_off_pin = TIE_LEVEL; // never toggles
endmodule // dcf_host

/* File: tb/dcf_link_assertions.sv */
// Purpose: pin-level checks on the link between controller and fifo
// Assumes: one clock, presetn asynchronous active low
// Notes: timing mode is tracked from the mode pin during full reset
`timescale 1ns/10ps
module dcf_link_assertions import dcf_pkg::*; (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// link pins
	input wire logic full_reset_n,
	input wire logic data_only_reset_n,
	input wire logic replay_request_n,
	input wire logic write_en_n,
	input wire logic read_en_n,
	input wire logic offset_access_select_n,
	input wire logic mode_serial_in,
	input wire logic tie_off_pin,
	input wire logic output_drive_en_n,
	input wire logic [DCF_DATA_W-1:0] write_data_in,
	input wire logic [DCF_DATA_W-1:0] read_data_out,
	input wire logic read_data_oe,
	input wire logic full_flag_n,
	input wire logic empty_flag_n
);
	logic fwft_ff;
	logic nxt_fwft;
	logic run_ok;

	// ****************
	// mode tracking
	// ****************
	assign nxt_fwft = full_reset_n ? fwft_ff : mode_serial_in;
	assign run_ok = full_reset_n && data_only_reset_n;
	// mode copy, taken while full reset is low
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) fwft_ff <= 1'b0;
		else fwft_ff <= nxt_fwft;
	end

	// ****************
	// checks
	// ****************
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	oe_follow_a: assert property (read_data_oe == !output_drive_en_n)
		else $error("output drive does not follow its enable");
	reset_clear_a: assert property (!run_ok |=> read_data_out == '0)
		else $error("output word not cleared by reset");
	tie_hold_a: assert property (full_reset_n |-> $stable(tie_off_pin))
		else $error("tie-off pin moved after reset");
	wr_pulse_a: assert property ($fell(write_en_n) |=> write_en_n)
		else $error("write strobe longer than one cycle");
	rd_pulse_a: assert property ($fell(read_en_n) |=> read_en_n)
		else $error("read strobe longer than one cycle");
	replay_std_a: assert property (run_ok && !fwft_ff && !replay_request_n |=> !empty_flag_n)
		else $error("replay did not show empty");
	replay_ft_a: assert property (run_ok && fwft_ff && !replay_request_n |=> empty_flag_n)
		else $error("replay did not drop output ready");
	empty_hold_a: assert property (run_ok && !fwft_ff && offset_access_select_n
		&& !empty_flag_n && !read_en_n |=> $stable(read_data_out))
		else $error("read of empty fifo changed output");
	first_word_a: assert property (run_ok && fwft_ff && offset_access_select_n
		&& empty_flag_n && !write_en_n && $past(write_en_n) && $past(write_en_n, 2)
		&& $past(write_en_n, 3) |-> ##4 (!empty_flag_n && read_data_out == $past(write_data_in, 4)))
		else $error("first word did not fall through in time");
	// main scenarios
	replay_c: cover property (!replay_request_n);
	ft_valid_c: cover property (fwft_ff && !empty_flag_n);
	full_c: cover property (!fwft_ff && !full_flag_n);
	oe_c: cover property (read_data_oe);
endmodule // dcf_link_assertions

/* File: tb/tb_top.sv */
// Purpose: drives the fifo controller over apb and checks the fifo through it
// Assumes: zero-wait apb slave, fifo depth 2048
// Notes: all checks go through the controller: its registers, plus pslverr on an unmapped read
`timescale 1ns/10ps
module tb_top import dcf_pkg::*; ();
	localparam int D = 2048;
	localparam logic [31:0] ALL = 32'hFFFF_FFFF;
	localparam logic [31:0] LOW2 = 32'h0000_0003;
	// serial offsets: full 6 above empty 3, empty bit 0 shifted first
	localparam logic [31:0] SER_OFS = 32'h0000_3003;
	localparam int SER_N = 2 * $clog2(D);
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, r;
	int n_mismatch = 0;
	int checked = 0;

	// ****************
	// structure
	// ****************
	dcf_link_if link_if ();
	dcf_host dcf_host_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .link(link_if));
	dcf_device #(.DEPTH(D)) dcf_device_i (.pclk(pclk), .presetn(presetn), .link(link_if));
	dcf_link_assertions dcf_link_assertions_i (.pclk(pclk), .presetn(presetn),
		.full_reset_n(link_if.full_reset_n), .data_only_reset_n(link_if.data_only_reset_n),
		.replay_request_n(link_if.replay_request_n), .write_en_n(link_if.write_en_n),
		.read_en_n(link_if.read_en_n), .offset_access_select_n(link_if.offset_access_select_n),
		.mode_serial_in(link_if.mode_serial_in), .tie_off_pin(link_if.tie_off_pin),
		.output_drive_en_n(link_if.output_drive_en_n), .write_data_in(link_if.write_data_in),
		.read_data_out(link_if.read_data_out), .read_data_oe(link_if.read_data_oe),
		.full_flag_n(link_if.full_flag_n), .empty_flag_n(link_if.empty_flag_n));

	// ****************
	// tasks
	// ****************
	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// one apb transfer, held until pready is seen high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		if (pready !== 1'b1) begin
			n_mismatch++;
			end_of_test();
		end
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x,
		input string nm);
		apb(1'b0, a, 32'h0000_0000);
		chk(nm, r & m, x);
	endtask
	// pops one word or offset and compares it
	task automatic pop(input logic [31:0] x);
		wr(DCF_REG_CMD, 32'h0000_0001);
		rd(DCF_REG_RDATA, ALL, x, "read_word");
	endtask
	function automatic logic [31:0] pat(input int i);
		return {14'h0000, 18'h2_5A5A ^ i[17:0]};
	endfunction

	// clock
	initial begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end

	// ****************
	// scenarios
	// ****************
	initial begin
		int c;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		rd(DCF_REG_STATUS, ALL, 32'h0000_0015, "status_idle");
		rd(DCF_REG_CTRL, ALL, DCF_CTRL_RESET, "ctrl_reset");
		apb(1'b0, 8'h14, 32'h0000_0000);
		chk("unmapped_err", {31'h0000_0000, e}, 32'h0000_0001);
		// offsets: defaults, then program empty 5 and full 9
		wr(DCF_REG_CTRL, 32'h0000_0008);
		pop(32'h0000_007F);
		pop(32'h0000_007F);
		wr(DCF_REG_WDATA, 32'h0000_0005);
		wr(DCF_REG_WDATA, 32'h0000_0009);
		pop(32'h0000_0005);
		pop(32'h0000_0009);
		wr(DCF_REG_CTRL, 32'h0000_0000);
		rd(DCF_REG_STATUS, ALL, 32'h0000_0015, "status_after_ofs");
		// fill past full, flags against count
		for (int i = 0; i <= D; i++) begin
			wr(DCF_REG_WDATA, pat(i));
			repeat (5) @(posedge pclk);
			c = (i < D) ? i + 1 : D;
			rd(DCF_REG_STATUS, ALL, {27'h000_0000, c <= D / 2, c >= 5, c <= D - 9, c != 0,
				c != D}, "status_fill");
		end
		rd(DCF_REG_RDATA, ALL, 32'h0000_0009, "q_before_read"); // last offset read stays
		pop(pat(0));
		pop(pat(1));
		wr(DCF_REG_CMD, 32'h0000_0008);
		pop(pat(0));
		// data reset keeps offsets
		wr(DCF_REG_CTRL, 32'h0000_0002);
		wr(DCF_REG_CTRL, 32'h0000_0000);
		pop(32'h0000_0000);
		rd(DCF_REG_STATUS, ALL, 32'h0000_0015, "status_data_reset");
		wr(DCF_REG_CTRL, 32'h0000_0008);
		pop(32'h0000_0005);
		pop(32'h0000_0009);
		// full reset into fall-through mode
		wr(DCF_REG_CTRL, 32'h0000_0005);
		wr(DCF_REG_CTRL, 32'h0000_0004);
		rd(DCF_REG_RDATA, ALL, 32'h0000_0000, "q_full_reset");
		rd(DCF_REG_STATUS, LOW2, 32'h0000_0002, "ft_idle");
		// serial method: large defaults, then shift in new offsets
		wr(DCF_REG_CTRL, 32'h0000_000C);
		pop(32'h0000_03FF);
		pop(32'h0000_03FF);
		for (int i = 0; i < SER_N; i++) begin
			wr(DCF_REG_CMD, {29'h0000_0000, SER_OFS[i], 2'h2});
		end
		pop(32'h0000_0003);
		pop(32'h0000_0006);
		wr(DCF_REG_CTRL, 32'h0000_0004);
		wr(DCF_REG_WDATA, pat(7));
		repeat (5) @(posedge pclk);
		rd(DCF_REG_RDATA, ALL, pat(7), "ft_first");
		rd(DCF_REG_STATUS, LOW2, 32'h0000_0000, "ft_ready");
		wr(DCF_REG_CMD, 32'h0000_0001);
		repeat (5) @(posedge pclk);
		rd(DCF_REG_STATUS, LOW2, 32'h0000_0002, "ft_popped");
		wr(DCF_REG_CMD, 32'h0000_0008);
		wr(DCF_REG_CTRL, 32'h0000_0006);
		wr(DCF_REG_CTRL, 32'h0000_0014);
		rd(DCF_REG_STATUS, LOW2, 32'h0000_0002, "ft_mode_kept");
		rd(DCF_REG_CTRL, ALL, 32'h0000_0014, "ctrl_drive_on");
		end_of_test();
	end
endmodule // tb_top
